// *** core/nvs_pkg.sv ***
/*
 * Package for the nonvolatile save/restore sequencer: timing figures,
 * derived cycle counts and the sequencer state type.
 * Assumes a single 40 MHz system clock; all counts derive from it.
 */
// Overview of operation
// (R1) power-up restore finishes within 20 ms of supply rising above trip level
// (R2) automatic save on supply drop is skipped when SRAM is unchanged since last cycle
// (R3) after automatic save triggers, writes stay enabled at most 25 ns
// (R4) array reads and writes ignored during save, restore, or low supply
// (R5) sleep command leads to low-power state within 8 ms
// (R6) after wake-up the device is ready within 20 ms
// (R7) device drops to standby within 100 us after a bus STOP
// (R8) a received software command is acted on within 500 us
// (R9) save or restore command locks bus input and output until it finishes
// (R10) save completes within 8 ms, commanded restore within 600 us, then lockout lifts
package nvs_pkg;
	// ----------------------------------------------------------------
	// clock and timing figures
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000;
	localparam int T_RESTORE_PU_MS = 20;
	localparam int T_SAVE_MS = 8;
	localparam int T_WRITE_WINDOW_NS = 25;
	localparam int T_WAKE_MS = 20;
	localparam int T_SLEEP_MS = 8;
	localparam int T_STANDBY_US = 100;
	localparam int T_CMD_US = 500;
	localparam int T_RESTORE_CMD_US = 600;

	// longest times round down, never below one cycle
	function automatic int cyc_dn(input longint ps);
		longint c;
		c = ps / CLK_PERIOD_PS;
		return (c < 1) ? 1 : int'(c);
	endfunction

	localparam int RESTORE_PU_CYC = cyc_dn(64'(T_RESTORE_PU_MS) * 64'd1000000000);
	localparam int SAVE_CYC = cyc_dn(64'(T_SAVE_MS) * 64'd1000000000);
	localparam int WRITE_WINDOW_CYC = cyc_dn(64'(T_WRITE_WINDOW_NS) * 64'd1000);
	localparam int WAKE_CYC = cyc_dn(64'(T_WAKE_MS) * 64'd1000000000);
	localparam int SLEEP_CYC = cyc_dn(64'(T_SLEEP_MS) * 64'd1000000000);
	localparam int STANDBY_CYC = cyc_dn(64'(T_STANDBY_US) * 64'd1000000);
	localparam int CMD_CYC = cyc_dn(64'(T_CMD_US) * 64'd1000000);
	localparam int RESTORE_CMD_CYC = cyc_dn(64'(T_RESTORE_CMD_US) * 64'd1000000);

	localparam int TMR_W = 20;
	localparam logic [TMR_W-1:0] TMR_RESET = 20'h00000;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		NVS_OFF,
		NVS_RESTORE,
		NVS_ACTIVE,
		NVS_STANDBY,
		NVS_CMD_DECODE,
		NVS_SAVE,
		NVS_CMD_RESTORE,
		NVS_SLEEP_ENTER,
		NVS_SLEEP,
		NVS_WAKE,
		NVS_WRITE_WINDOW,
		NVS_AUTO_SAVE
	} nvs_state_t;

	typedef enum logic [1:0] {
		NVS_CMD_SAVE,
		NVS_CMD_RESTORE_OP,
		NVS_CMD_SLEEP,
		NVS_CMD_NONE
	} nvs_cmd_t;
endpackage

// *** core/nvs_seq.sv ***
/*
 * Sequencer for the nonvolatile side of a serial SRAM: power-up restore,
 * automatic save on supply loss, commanded save/restore, sleep, standby.
 * Assumes a bus protocol engine on sys_clk that decodes commands and STOP,
 * and an asynchronous supply comparator that must be synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
module nvs_seq #(
	parameter int RESTORE_PU_CYC = nvs_pkg::RESTORE_PU_CYC,
	parameter int SAVE_CYC = nvs_pkg::SAVE_CYC,
	parameter int WAKE_CYC = nvs_pkg::WAKE_CYC,
	parameter int SLEEP_CYC = nvs_pkg::SLEEP_CYC,
	parameter int CMD_CYC = nvs_pkg::CMD_CYC,
	parameter int RESTORE_CMD_CYC = nvs_pkg::RESTORE_CMD_CYC,
	parameter int STANDBY_CYC = nvs_pkg::STANDBY_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic supply_ok_async,
	input wire logic auto_save_on_powerdown,
	input wire logic sram_write,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_code,
	input wire logic wake_req,
	input wire logic bus_stop,
	input wire logic bus_active,
	output logic array_access_en,
	output logic sram_write_en,
	output logic bus_lockout,
	output logic nv_store_busy,
	output logic nv_recall_busy,
	output logic sleep_mode,
	output logic standby_mode,
	output logic ready
);
	// ----------------------------------------------------------------
	// supply comparator synchroniser
	// ----------------------------------------------------------------
	// the comparator is not timed to sys_clk, so it gets two flops
	logic sup_meta_q;
	logic sup_ok_q;

	// second stage alone feeds the logic so metastability cannot spread
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sup_meta_q <= 1'b0;
			sup_ok_q <= 1'b0;
		end else begin
			sup_meta_q <= supply_ok_async;
			sup_ok_q <= sup_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// state, latched command and the one shared timer
	nvs_pkg::nvs_state_t state_q;
	nvs_pkg::nvs_cmd_t cmd_q;
	logic [nvs_pkg::TMR_W-1:0] tmr_q;
	logic dirty_q;
	logic timer_done;

	// zero means the phase in hand has run out
	assign timer_done = (tmr_q == nvs_pkg::TMR_RESET);

	// one down-counter serves every timed phase; load is count minus one
	function automatic logic [nvs_pkg::TMR_W-1:0] ld(input int cyc);
		return nvs_pkg::TMR_W'(cyc - 1);
	endfunction

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= nvs_pkg::NVS_OFF;
			tmr_q <= nvs_pkg::TMR_RESET;
			cmd_q <= nvs_pkg::NVS_CMD_NONE;
		end else if (!sup_ok_q && state_q != nvs_pkg::NVS_OFF && state_q != nvs_pkg::NVS_WRITE_WINDOW
				&& state_q != nvs_pkg::NVS_AUTO_SAVE) begin
			// supply loss preempts every state but off, the write window and auto save; save only if enabled and dirty
			if (auto_save_on_powerdown && dirty_q) begin // R2
				state_q <= nvs_pkg::NVS_WRITE_WINDOW; // R3
				tmr_q <= ld(nvs_pkg::WRITE_WINDOW_CYC); // R3
			end else begin
				state_q <= nvs_pkg::NVS_OFF;
			end
		end else begin
			// the timer parks at zero, so phases with no load of their own never wrap
			if (!timer_done) begin
				tmr_q <= tmr_q - 1'b1;
			end
			unique case (state_q)
				nvs_pkg::NVS_OFF: begin
					if (sup_ok_q) begin
						state_q <= nvs_pkg::NVS_RESTORE;
						tmr_q <= ld(RESTORE_PU_CYC); // R1
					end
				end
				nvs_pkg::NVS_RESTORE: begin
					// a fresh part waits in standby until the bus is used
					if (timer_done) begin
						state_q <= nvs_pkg::NVS_STANDBY; // R1
					end
				end
				nvs_pkg::NVS_ACTIVE: begin
					if (cmd_valid) begin
						state_q <= nvs_pkg::NVS_CMD_DECODE;
						cmd_q <= nvs_pkg::nvs_cmd_t'(cmd_code);
						tmr_q <= ld(CMD_CYC); // R8
					end else if (bus_stop) begin
						state_q <= nvs_pkg::NVS_STANDBY; // R7
					end
				end
				nvs_pkg::NVS_STANDBY: begin
					// any bus traffic brings the interface out of standby
					if (bus_active) begin
						state_q <= nvs_pkg::NVS_ACTIVE;
					end
				end
				nvs_pkg::NVS_CMD_DECODE: begin
					// acted on at once, well inside the processing window
					unique case (cmd_q)
						nvs_pkg::NVS_CMD_SAVE: begin
							state_q <= nvs_pkg::NVS_SAVE; // R8
							tmr_q <= ld(SAVE_CYC); // R10
						end
						nvs_pkg::NVS_CMD_RESTORE_OP: begin
							state_q <= nvs_pkg::NVS_CMD_RESTORE; // R8
							tmr_q <= ld(RESTORE_CMD_CYC); // R10
						end
						nvs_pkg::NVS_CMD_SLEEP: begin
							state_q <= nvs_pkg::NVS_SLEEP_ENTER; // R8
							tmr_q <= ld(SLEEP_CYC); // R5
						end
						nvs_pkg::NVS_CMD_NONE: begin
							// a STOP in the decode cycle is not lost, or the part would stay active
							if (bus_stop) begin
								state_q <= nvs_pkg::NVS_STANDBY; // R7
							end else begin
								state_q <= nvs_pkg::NVS_ACTIVE;
							end
						end
					endcase
				end
				nvs_pkg::NVS_SAVE, nvs_pkg::NVS_CMD_RESTORE: begin
					if (timer_done) begin
						state_q <= nvs_pkg::NVS_STANDBY; // R10
					end
				end
				nvs_pkg::NVS_SLEEP_ENTER: begin
					if (timer_done) begin
						state_q <= nvs_pkg::NVS_SLEEP; // R5
					end
				end
				nvs_pkg::NVS_SLEEP: begin
					// wake needs no supply check; a drop while asleep takes the save path above
					if (wake_req) begin
						state_q <= nvs_pkg::NVS_WAKE;
						tmr_q <= ld(WAKE_CYC); // R6
					end
				end
				nvs_pkg::NVS_WAKE: begin
					if (timer_done) begin
						state_q <= nvs_pkg::NVS_STANDBY; // R6
					end
				end
				nvs_pkg::NVS_WRITE_WINDOW: begin
					if (timer_done) begin
						state_q <= nvs_pkg::NVS_AUTO_SAVE;
						tmr_q <= ld(SAVE_CYC);
					end
				end
				nvs_pkg::NVS_AUTO_SAVE: begin
					// save runs on the storage capacitor, then the part is off
					if (timer_done) begin
						state_q <= nvs_pkg::NVS_OFF;
					end
				end
				default: begin
					state_q <= nvs_pkg::NVS_OFF;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// dirty tracking
	// ----------------------------------------------------------------
	// every nonvolatile cycle clears it, so only later writes count
	// a write in the same cycle a save ends is shut out by sram_write_en, so the clear wins
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dirty_q <= 1'b0;
		end else if (sram_write && sram_write_en) begin
			dirty_q <= 1'b1; // R2
		end else if ((state_q == nvs_pkg::NVS_RESTORE || state_q == nvs_pkg::NVS_SAVE
				|| state_q == nvs_pkg::NVS_CMD_RESTORE || state_q == nvs_pkg::NVS_AUTO_SAVE) && timer_done) begin
			dirty_q <= 1'b0; // R2
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// status decodes straight from the state register; sample it on sys_clk only
	logic nv_busy;
	assign nv_store_busy = (state_q == nvs_pkg::NVS_SAVE) || (state_q == nvs_pkg::NVS_AUTO_SAVE);
	assign nv_recall_busy = (state_q == nvs_pkg::NVS_RESTORE) || (state_q == nvs_pkg::NVS_CMD_RESTORE);
	assign nv_busy = nv_store_busy || nv_recall_busy;
	// the synchronised supply flag gates access, two edges after the pin falls
	assign array_access_en = sup_ok_q && !nv_busy && (state_q == nvs_pkg::NVS_ACTIVE
		|| state_q == nvs_pkg::NVS_STANDBY || state_q == nvs_pkg::NVS_CMD_DECODE); // R4
	// writes stay open only for the short window after supply loss
	assign sram_write_en = array_access_en || (state_q == nvs_pkg::NVS_WRITE_WINDOW); // R3
	// low supply locks the bus too, since no command can be trusted then
	assign bus_lockout = nv_busy || !sup_ok_q; // R9
	// mode flags for the power control outside; ready means the array answers
	assign sleep_mode = (state_q == nvs_pkg::NVS_SLEEP);
	assign standby_mode = (state_q == nvs_pkg::NVS_STANDBY); // R7
	assign ready = array_access_en; // R6
endmodule
`default_nettype wire

// *** tb/nvs_master.sv ***
/* bus master model: commands and STOPs
   assumes callers sit on a falling edge */
`timescale 1ns/10ps
`default_nettype none
module nvs_master (
	input wire logic sys_clk,
	output logic cmd_valid,
	output logic [1:0] cmd_code,
	output logic bus_active,
	output logic bus_stop
);
	// idle bus at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 2'h3;
		bus_active = 1'b0;
		bus_stop = 1'b0;
	end
	// wake the bus, wait, strobe; code scrambled once unqualified
	task automatic send(input logic [1:0] c, input int gap);
		bus_active = 1'b1;
		@(negedge sys_clk);
		bus_active = 1'b0;
		repeat (gap) @(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		cmd_code = ~c;
	endtask
	task automatic stop();
		bus_active = 1'b1;
		@(negedge sys_clk);
		bus_active = 1'b0;
		bus_stop = 1'b1;
		@(negedge sys_clk);
		bus_stop = 1'b0;
	endtask
endmodule
`default_nettype wire

// *** tb/nvs_seq_properties.sv ***
/* port checker for the save/restore sequencer
   assumes it is bound into nvs_seq with shortened counts */
`timescale 1ns/10ps
`default_nettype none
module nvs_chk #(parameter int SV_MAX = 31, parameter int SL_MAX = 13, parameter int WK_MAX = 12) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_code,
	input wire logic wake_req,
	input wire logic bus_stop,
	input wire logic array_access_en,
	input wire logic sram_write_en,
	input wire logic bus_lockout,
	input wire logic nv_store_busy,
	input wire logic nv_recall_busy,
	input wire logic sleep_mode,
	input wire logic standby_mode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// active means open, not idle and not locked
	property p_lock; bus_lockout |-> !array_access_en; endproperty
	a_lock: assert property (p_lock) else $error("access open under lockout");
	property p_busy; nv_store_busy || nv_recall_busy |-> bus_lockout; endproperty
	a_busy: assert property (p_busy) else $error("bus open while busy");
	property p_wwin; sram_write_en && !array_access_en |=> !sram_write_en; endproperty
	a_wwin: assert property (p_wwin) else $error("write window too long");
	property p_save; $rose(nv_store_busy) |-> ##[1:SV_MAX] !nv_store_busy; endproperty
	a_save: assert property (p_save) else $error("save too long");
	property p_cmd; cmd_valid && cmd_code == 2'h0 && array_access_en && !standby_mode |-> ##2 nv_store_busy; endproperty
	a_cmd: assert property (p_cmd) else $error("save not started");
	property p_slp; cmd_valid && cmd_code == 2'h2 && array_access_en && !standby_mode |-> ##[2:SL_MAX] sleep_mode;
	endproperty
	a_slp: assert property (p_slp) else $error("sleep not entered");
	property p_stop; bus_stop && array_access_en && !standby_mode |=> standby_mode; endproperty
	a_stop: assert property (p_stop) else $error("standby missed");
	property p_wake; wake_req && sleep_mode |-> ##[1:WK_MAX] array_access_en; endproperty
	a_wake: assert property (p_wake) else $error("wake too slow");
	property p_rel; $fell(nv_recall_busy) && !bus_lockout |-> standby_mode; endproperty
	a_rel: assert property (p_rel) else $error("restore did not end in standby");
	c_save: cover property (nv_store_busy);
	c_sleep: cover property (sleep_mode);
	c_wwin: cover property (sram_write_en && !array_access_en);
endmodule
bind nvs_seq nvs_chk #(.SV_MAX(SAVE_CYC + 1), .SL_MAX(SLEEP_CYC + 3), .WK_MAX(WAKE_CYC + 2)) u_chk (.sys_clk, .rst_n,
	.cmd_valid, .cmd_code, .wake_req, .bus_stop, .array_access_en, .sram_write_en, .bus_lockout, .nv_store_busy,
	.nv_recall_busy, .sleep_mode, .standby_mode);
`default_nettype wire

// *** tb/nvs_seq_tb.sv ***
/* bench for nvs_seq with a bus master model
   assumes shortened counts, all inputs driven on falling edges */
`timescale 1ns/10ps
`default_nettype none
module nvs_seq_tb;
	localparam int RPU = 20, SV = 30, RC = 15, SL = 10, WK = 10;
	logic sys_clk = 1'b0;
	logic rst_n, supply_ok_async, auto_save_on_powerdown, sram_write, wake_req, cmd_valid, bus_active, bus_stop;
	logic array_access_en, sram_write_en, bus_lockout, nv_store_busy, nv_recall_busy, sleep_mode, standby_mode, ready;
	logic [1:0] cmd_code;
	int n_fail = 0, comparisons = 0;
	nvs_seq #(.RESTORE_PU_CYC(RPU), .SAVE_CYC(SV), .WAKE_CYC(WK), .SLEEP_CYC(SL), .RESTORE_CMD_CYC(RC)) u_dut (
		.sys_clk, .rst_n, .supply_ok_async, .auto_save_on_powerdown, .sram_write, .cmd_valid, .cmd_code, .wake_req,
		.bus_stop, .bus_active, .array_access_en, .sram_write_en, .bus_lockout, .nv_store_busy, .nv_recall_busy,
		.sleep_mode, .standby_mode, .ready);
	nvs_master u_mst (.sys_clk, .cmd_valid, .cmd_code, .bus_active, .bus_stop);
	// 40 MHz system clock
	always #12.5 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return ready;
			1: return sleep_mode;
			2: return nv_store_busy;
			default: return nv_recall_busy;
		endcase
	endfunction
	// bounded wait so a stuck sequencer fails instead of hanging
	task automatic wait_for(input int s, input logic v, input int lim, input string nm);
		for (int k = 0; k < lim && sig(s) !== v; k++) @(negedge sys_clk);
		chk(nm, v, sig(s));
	endtask
	task automatic t_power_up();
		supply_ok_async = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk("recall busy", 1'b1, nv_recall_busy);
		chk("access in recall", 1'b0, array_access_en);
		wait_for(0, 1'b1, RPU, "ready after recall");
	endtask
	task automatic t_drop(input logic dirty, input logic auto_on);
		auto_save_on_powerdown = auto_on;
		sram_write = dirty;
		@(negedge sys_clk);
		sram_write = 1'b0;
		supply_ok_async = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk("access at low supply", 1'b0, array_access_en);
		chk("auto save", dirty & auto_on, nv_store_busy | sram_write_en);
		chk("write window", dirty & auto_on, sram_write_en);
		@(negedge sys_clk);
		chk("auto save busy", dirty & auto_on, nv_store_busy);
		chk("write window shut", 1'b0, sram_write_en);
		wait_for(2, 1'b0, SV + 2, "auto save end");
	endtask
	task automatic t_op(input logic [1:0] c, input int s, input int lim);
		u_mst.send(c, 1);
		@(negedge sys_clk);
		chk("op busy", 1'b1, sig(s));
		chk("lockout", 1'b1, bus_lockout);
		chk("write gate in op", 1'b0, sram_write_en);
		wait_for(0, 1'b1, lim, "op done");
	endtask
	task automatic t_sleep();
		u_mst.send(2'h2, 0);
		wait_for(1, 1'b1, SL + 3, "sleep entry");
		wake_req = 1'b1;
		@(negedge sys_clk);
		wake_req = 1'b0;
		wait_for(0, 1'b1, WK + 3, "wake ready");
	endtask
	// a command that needs no action leaves the part active until a STOP
	task automatic t_none();
		u_mst.send(2'h3, 1);
		@(negedge sys_clk);
		chk("no action back to active", 1'b1, ready & !standby_mode);
		chk("no action lockout", 1'b0, bus_lockout);
		u_mst.stop();
		chk("standby after no action", 1'b1, standby_mode);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// watchdog: the whole sequence needs a few hundred cycles
	initial begin
		#(25 * 3000);
		n_fail++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		rst_n = 1'b0;
		supply_ok_async = 1'b0;
		auto_save_on_powerdown = 1'b1;
		sram_write = 1'b0;
		wake_req = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk("lockout in reset", 1'b1, bus_lockout);
		chk("access in reset", 1'b0, array_access_en);
		rst_n = 1'b1;
		t_power_up();
		t_drop(1'b0, 1'b1);
		t_power_up();
		u_mst.stop();
		chk("standby", 1'b1, standby_mode);
		t_op(2'h0, 2, SV + 2);
		t_op(2'h1, 3, RC + 2);
		t_none();
		t_sleep();
		t_drop(1'b1, 1'b0);
		t_power_up();
		t_drop(1'b1, 1'b1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
